/* File: logic/mrtl_regs.svh */
// Constants of the memory range type lookup
`ifndef MRTL_REGS_SVH
`define MRTL_REGS_SVH
`define MRTL_ADDR_W      32
`define MRTL_PAGE_LSB    12
`define MRTL_VAR_N       8
`define MRTL_FIX_N       88
`define MRTL_FIX64_N     8
`define MRTL_FIX16_N     16
`define MRTL_FIX64_LIM   32'h0007ffff
`define MRTL_FIX16_LIM   32'h000bffff
`define MRTL_FIX4_LIM    32'h000fffff
`define MRTL_FIX16_BASE  32'h00080000
`define MRTL_FIX4_BASE   32'h000c0000
`define MRTL_LARGE_LSB   22
`define MRTL_LOOKUP_LAT  1
`define MRTL_RST_ENABLE  1'b0
`define MRTL_RST_VALID   8'h00
`endif

/* File: logic/mrtl_pkg.sv */
// Types of the memory range type lookup
package mrtl_pkg;
  typedef enum logic [2:0] {
    MRTL_UNCACHEABLE     = 3'h0,
    MRTL_WRITE_COMBINING = 3'h1,
    MRTL_WRITE_THROUGH   = 3'h4,
    MRTL_WRITE_PROTECTED = 3'h5,
    MRTL_WRITE_BACK      = 3'h6
  } mrtl_type_t;

  typedef struct packed {
    logic [19:0] range_base;
    logic [2:0]  kind;
  } mrtl_base_t;

  typedef struct packed {
    logic [19:0] range_mask;
    logic        valid;
  } mrtl_mask_t;

  typedef struct packed {
    logic       range_enable;
    logic       fixed_range_enable;
    logic [2:0] default_kind;
  } mrtl_ctrl_t;

  typedef struct packed {
    logic [2:0] kind;
    logic       split_4k;
    logic       undefined_overlap;
  } mrtl_result_t;
endpackage : mrtl_pkg

/* File: logic/mrtl_lookup.sv */
// Physical address memory type resolver
`timescale 1ns/1ns
`include "mrtl_regs.svh"
module mrtl_lookup (
  input  wire logic                              clock_in,
  input  wire logic                              reset_in,
  input  wire logic                              req_valid_in,
  input  wire logic [`MRTL_ADDR_W-1:0]           phys_addr_in,
  input  wire logic                              large_page_in,
  input  wire logic                              fixed_supported_in,
  input  wire logic [3:0]                        variable_range_count_in,
  input  wire logic                              ctrl_we_in,
  input  wire mrtl_pkg::mrtl_ctrl_t              ctrl_in,
  input  wire logic [`MRTL_FIX_N*3-1:0]          fixed_types_in,
  input  wire logic                              var_we_in,
  input  wire logic [2:0]                        var_idx_in,
  input  wire mrtl_pkg::mrtl_base_t              var_base_in,
  input  wire mrtl_pkg::mrtl_mask_t              var_mask_in,
  output logic                                   rsp_valid_out,
  output mrtl_pkg::mrtl_result_t                 rsp_out,
  output mrtl_pkg::mrtl_ctrl_t                   ctrl_out,
  output logic [`MRTL_VAR_N-1:0]                 valid_flags_out
);
  mrtl_pkg::mrtl_ctrl_t ctrl_reg;
  mrtl_pkg::mrtl_base_t base_reg [`MRTL_VAR_N];
  mrtl_pkg::mrtl_mask_t mask_reg [`MRTL_VAR_N];
  logic [`MRTL_VAR_N-1:0] valid_reg;
  logic                   rsp_valid_reg;
  mrtl_pkg::mrtl_result_t rsp_reg;
  logic [`MRTL_VAR_N-1:0] hit;
  logic [`MRTL_VAR_N-1:0] uc_hit;
  logic [2:0]             fix_kind;
  logic                   fix_hit;
  logic [2:0]             var_kind;
  logic                   var_any;
  logic                   var_undef;
  mrtl_pkg::mrtl_result_t rsp_next;

  // Index of the fixed field covering a low address
  function automatic logic [6:0] fix_index(input logic [`MRTL_ADDR_W-1:0] a);
    logic [`MRTL_ADDR_W-1:0] off;
    off = 32'h00000000;
    if (a <= `MRTL_FIX64_LIM) begin
      fix_index = 7'(a[18:16]);
    end else if (a <= `MRTL_FIX16_LIM) begin
      off = a - `MRTL_FIX16_BASE;
      fix_index = 7'(`MRTL_FIX64_N) + 7'(off[17:14]);
    end else begin
      off = a - `MRTL_FIX4_BASE;
      fix_index = 7'(`MRTL_FIX64_N + `MRTL_FIX16_N) + 7'(off[17:12]);
    end
  endfunction : fix_index

  // Control register, reset clears enable
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_reg <= '0;
      ctrl_reg.range_enable <= `MRTL_RST_ENABLE;
    end else if (ctrl_we_in) begin
      ctrl_reg <= ctrl_in;
    end
  end

  // Variable entries; only valid flags have a reset value
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      valid_reg <= `MRTL_RST_VALID;
    end else if (var_we_in) begin
      valid_reg[var_idx_in] <= var_mask_in.valid;
    end
  end

  always_ff @(posedge clock_in) begin
    if (var_we_in) begin
      base_reg[var_idx_in] <= var_base_in;
      mask_reg[var_idx_in] <= var_mask_in;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `MRTL_VAR_N; gi++) begin : g_var
      // Page-granular masked compare
      assign hit[gi] = valid_reg[gi] && (gi < variable_range_count_in) &&
        ((phys_addr_in[31:12] & mask_reg[gi].range_mask) ==
         (base_reg[gi].range_base & mask_reg[gi].range_mask));
      // Matching uncacheable entry, watched by the overlap check
      assign uc_hit[gi] = hit[gi] && (base_reg[gi].kind == 3'h0);
    end
  endgenerate

  always_comb begin
    fix_hit  = fixed_supported_in && ctrl_reg.fixed_range_enable &&
               (phys_addr_in <= `MRTL_FIX4_LIM);
    fix_kind = fixed_types_in[fix_index(phys_addr_in)*3 +: 3];
  end

  // Overlap resolution across matching entries
  always_comb begin
    logic first;
    logic any_uc;
    logic only_wt_wb;
    logic same;
    first = 1'b1;
    any_uc = 1'b0;
    only_wt_wb = 1'b1;
    same = 1'b1;
    var_kind = 3'h0;
    for (int i = 0; i < `MRTL_VAR_N; i++) begin
      if (hit[i]) begin
        if (!first && base_reg[i].kind != var_kind) begin
          same = 1'b0;
        end
        if (first) begin
          var_kind = base_reg[i].kind;
        end
        first = 1'b0;
        if (base_reg[i].kind == mrtl_pkg::MRTL_UNCACHEABLE) begin
          any_uc = 1'b1;
        end
        if (base_reg[i].kind != mrtl_pkg::MRTL_WRITE_THROUGH &&
            base_reg[i].kind != mrtl_pkg::MRTL_WRITE_BACK) begin
          only_wt_wb = 1'b0;
        end
      end
    end
    var_any = !first;
    var_undef = 1'b0;
    if (any_uc) begin
      var_kind = mrtl_pkg::MRTL_UNCACHEABLE;
    end else if (!same && only_wt_wb) begin
      var_kind = mrtl_pkg::MRTL_WRITE_THROUGH;
    end else if (!same) begin
      var_undef = var_any;
    end
  end

  always_comb begin
    rsp_next = '0;
    rsp_next.kind = ctrl_reg.default_kind;
    if (!ctrl_reg.range_enable) begin
      rsp_next.kind = mrtl_pkg::MRTL_UNCACHEABLE;
    end else if (fix_hit) begin
      rsp_next.kind = fix_kind;
    end else if (var_any) begin
      rsp_next.kind = var_kind;
      rsp_next.undefined_overlap = var_undef;
    end
    // Large page over the low region whose type differs from fixed typing
    rsp_next.split_4k = large_page_in && ctrl_reg.range_enable && fixed_supported_in &&
      ctrl_reg.fixed_range_enable &&
      (phys_addr_in[31:`MRTL_LARGE_LSB] == 10'h000) &&
      ((var_any ? var_kind : ctrl_reg.default_kind) != fix_kind);
  end

  // Registered answer, one cycle latency
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rsp_valid_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      rsp_valid_reg <= req_valid_in;
      if (req_valid_in) begin
        rsp_reg <= rsp_next;
      end
    end
  end

  assign rsp_valid_out   = rsp_valid_reg;
  assign rsp_out         = rsp_reg;
  assign ctrl_out        = ctrl_reg;
  assign valid_flags_out = valid_reg;

  property p_disabled_uc;
    @(posedge clock_in) disable iff (reset_in)
      (req_valid_in && !ctrl_reg.range_enable) |=> (rsp_out.kind == 3'h0);
  endproperty
  a_disabled_uc: assert property (p_disabled_uc) else $error("disabled not uc");
  property p_fixed_first;
    @(posedge clock_in) disable iff (reset_in)
      (req_valid_in && ctrl_reg.range_enable && fix_hit) |=> (rsp_out.kind == $past(fix_kind));
  endproperty
  a_fixed_first: assert property (p_fixed_first) else $error("fixed not first");
  property p_fix_top;
    @(posedge clock_in) disable iff (reset_in)
      (phys_addr_in == 32'h000fffff) |-> (fix_index(phys_addr_in) == 7'h57);
  endproperty
  a_fix_top: assert property (p_fix_top) else $error("fixed index wrong");
  property p_invalid_no_hit;
    @(posedge clock_in) disable iff (reset_in) (hit & ~valid_reg) == '0;
  endproperty
  a_invalid_no_hit: assert property (p_invalid_no_hit) else $error("invalid hit");
  property p_count_limit;
    @(posedge clock_in) disable iff (reset_in)
      (variable_range_count_in == 4'h0) |-> !var_any;
  endproperty
  a_count_limit: assert property (p_count_limit) else $error("count ignored");
  property p_uc_wins;
    @(posedge clock_in) disable iff (reset_in)
      (req_valid_in && ctrl_reg.range_enable && !fix_hit && (|uc_hit)) |=>
        (rsp_out.kind == 3'h0);
  endproperty
  a_uc_wins: assert property (p_uc_wins) else $error("uc lost");
  property p_reset_clear;
    @(posedge clock_in) reset_in |=> (valid_reg == '0 && !ctrl_reg.range_enable);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset not cleared");
  property p_latency;
    @(posedge clock_in) disable iff (reset_in) req_valid_in |=> rsp_valid_out;
  endproperty
  a_latency: assert property (p_latency) else $error("late answer");
  property p_split_low;
    @(posedge clock_in) disable iff (reset_in)
      rsp_out.split_4k |-> $past(phys_addr_in[31:22]) == 10'h000 || !$past(req_valid_in);
  endproperty
  a_split_low: assert property (p_split_low) else $error("split high");
  c_fixed: cover property (@(posedge clock_in) req_valid_in && fix_hit);
  c_var: cover property (@(posedge clock_in) req_valid_in && var_any && !fix_hit);
  c_split: cover property (@(posedge clock_in) rsp_out.split_4k);
endmodule : mrtl_lookup

/* File: sim/mrtl_far_model.sv */
// Translation side model that consumes lookup results
`timescale 1ns/1ns
module mrtl_far_model (
  input  wire logic                   clock_in,
  input  wire logic                   reset_in,
  input  wire logic                   rsp_valid_in,
  input  wire mrtl_pkg::mrtl_result_t rsp_in,
  output logic [15:0]                 seen_count_out,
  output logic [2:0]                  held_kind_out
);
  // Type kept beside the translation until the next fill
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      seen_count_out <= 16'h0000;
      held_kind_out  <= 3'h0;
    end else if (rsp_valid_in) begin
      seen_count_out <= seen_count_out + 16'h0001;
      held_kind_out  <= rsp_in.kind;
    end
  end
endmodule : mrtl_far_model

/* File: sim/mrtl_lookup_tb_top.sv */
// Bench of the memory range type lookup
`timescale 1ns/1ns
`include "mrtl_regs.svh"
module mrtl_lookup_tb_top;
  localparam logic [2:0] k_uc = 3'h0;
  localparam logic [2:0] k_wc = 3'h1;
  localparam logic [2:0] k_wt = 3'h4;
  localparam logic [2:0] k_wp = 3'h5;
  localparam logic [2:0] k_wb = 3'h6;
  logic                     clock_in = 1'b0;
  logic                     reset_in = 1'b1;
  logic                     req_valid_in = 1'b0;
  logic [31:0]              phys_addr_in = 32'h0;
  logic                     large_page_in = 1'b0;
  logic                     fixed_supported_in = 1'b1;
  logic [3:0]               variable_range_count_in = 4'h8;
  logic                     ctrl_we_in = 1'b0;
  mrtl_pkg::mrtl_ctrl_t     ctrl_in = '0;
  logic [`MRTL_FIX_N*3-1:0] fixed_types_in = {`MRTL_FIX_N{3'h5}};
  logic                     var_we_in = 1'b0;
  logic [2:0]               var_idx_in = 3'h0;
  mrtl_pkg::mrtl_base_t     var_base_in = '0;
  mrtl_pkg::mrtl_mask_t     var_mask_in = '0;
  logic                     rsp_valid_out;
  mrtl_pkg::mrtl_result_t   rsp_out;
  mrtl_pkg::mrtl_ctrl_t     ctrl_out;
  logic [7:0]               valid_flags_out;
  logic [15:0]              seen_count;
  logic [2:0]               held_kind;
  int                       fails = 0;
  int                       check_count = 0;
  int                       issued = 0;

  always #5 clock_in = ~clock_in;

  mrtl_lookup mrtl_lookup_inst (.clock_in(clock_in), .reset_in(reset_in),
    .req_valid_in(req_valid_in), .phys_addr_in(phys_addr_in), .large_page_in(large_page_in),
    .fixed_supported_in(fixed_supported_in), .variable_range_count_in(variable_range_count_in),
    .ctrl_we_in(ctrl_we_in), .ctrl_in(ctrl_in), .fixed_types_in(fixed_types_in),
    .var_we_in(var_we_in), .var_idx_in(var_idx_in), .var_base_in(var_base_in),
    .var_mask_in(var_mask_in), .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out),
    .ctrl_out(ctrl_out), .valid_flags_out(valid_flags_out));
  mrtl_far_model mrtl_far_model_inst (.clock_in(clock_in), .reset_in(reset_in),
    .rsp_valid_in(rsp_valid_out), .rsp_in(rsp_out), .seen_count_out(seen_count),
    .held_kind_out(held_kind));

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic step();
    @(posedge clock_in);
    #1;
  endtask : step

  // Config writes leave one idle cycle so strobes never toggle twice
  task automatic set_ctrl(input logic en, input logic fe, input logic [2:0] dk);
    req_valid_in = 1'b0;
    ctrl_in = '{range_enable: en, fixed_range_enable: fe, default_kind: dk};
    ctrl_we_in = 1'b1;
    step();
    ctrl_we_in = 1'b0;
    step();
  endtask : set_ctrl

  task automatic set_var(input logic [2:0] i, input logic [19:0] b, input logic [2:0] k,
                         input logic [19:0] m, input logic v);
    req_valid_in = 1'b0;
    var_idx_in = i;
    var_base_in = '{range_base: b, kind: k};
    var_mask_in = '{range_mask: m, valid: v};
    var_we_in = 1'b1;
    step();
    var_we_in = 1'b0;
    step();
  endtask : set_var

  task automatic look(input logic [31:0] a, input logic lg, input logic [2:0] ek,
                      input logic es);
    req_valid_in = 1'b1;
    phys_addr_in = a;
    large_page_in = lg;
    step();
    issued++;
    chk("rsp_valid", 16'h1, {15'h0, rsp_valid_out});
    chk("kind", {13'h0, ek}, {13'h0, rsp_out.kind});
    chk("split", {15'h0, es}, {15'h0, rsp_out.split_4k});
  endtask : look

  initial begin
    #100000;
    fails++;
    stop_test();
  end

  initial begin
    fixed_types_in[3*7+:3] = k_wt;
    fixed_types_in[3*8+:3] = k_wc;
    fixed_types_in[3*24+:3] = k_uc;
    fixed_types_in[3*87+:3] = k_wb;
    repeat (20) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    chk("ctrl", 16'h0, {11'h0, ctrl_out});
    chk("valid_flags", 16'h0, {8'h0, valid_flags_out});
    look(32'h000c0000, 1'b0, k_uc, 1'b0);
    set_var(3'h0, 20'h00400, k_wb, 20'hffc00, 1'b1);
    set_var(3'h1, 20'h00400, k_uc, 20'hffc00, 1'b0);
    look(32'h00400000, 1'b0, k_uc, 1'b0);
    set_ctrl(1'b1, 1'b1, k_wp);
    look(32'h0007ffff, 1'b0, k_wt, 1'b0);
    look(32'h00080000, 1'b0, k_wc, 1'b0);
    look(32'h000bffff, 1'b0, k_wp, 1'b0);
    look(32'h000c0fff, 1'b0, k_uc, 1'b0);
    look(32'h000c1000, 1'b0, k_wp, 1'b0);
    look(32'h000fffff, 1'b0, k_wb, 1'b0);
    look(32'h00100000, 1'b0, k_wp, 1'b0);
    look(32'h007ff123, 1'b0, k_wb, 1'b0);
    look(32'h00800000, 1'b0, k_wp, 1'b0);
    set_ctrl(1'b0, 1'b1, k_wp);
    set_var(3'h1, 20'h00400, k_uc, 20'hffc00, 1'b1);
    set_var(3'h2, 20'h00800, k_wb, 20'hffc00, 1'b1);
    set_var(3'h3, 20'h00800, k_wt, 20'hffc00, 1'b1);
    set_var(3'h4, 20'h00000, k_wb, 20'hffc00, 1'b1);
    set_var(3'h7, 20'h01000, k_wc, 20'hfffff, 1'b1);
    set_ctrl(1'b1, 1'b1, k_wp);
    chk("valid_flags", 16'h9f, {8'h0, valid_flags_out});
    look(32'h00400000, 1'b0, k_uc, 1'b0);
    look(32'h00900000, 1'b0, k_wt, 1'b0);
    chk("undefined", 16'h0, {15'h0, rsp_out.undefined_overlap});
    look(32'h01000fff, 1'b0, k_wc, 1'b0);
    look(32'h01001000, 1'b0, k_wp, 1'b0);
    look(32'h00000000, 1'b1, k_wp, 1'b1);
    look(32'h00000000, 1'b0, k_wp, 1'b0);
    look(32'h00400000, 1'b1, k_uc, 1'b0);
    fixed_supported_in = 1'b0;
    look(32'h00000000, 1'b0, k_wb, 1'b0);
    fixed_supported_in = 1'b1;
    set_ctrl(1'b1, 1'b0, k_wp);
    look(32'h000c0000, 1'b0, k_wb, 1'b0);
    // Valid bit cleared around the entry update
    set_var(3'h5, 20'h01000, k_wb, 20'hffc00, 1'b0);
    set_var(3'h5, 20'h01000, k_wb, 20'hffc00, 1'b1);
    look(32'h01000fff, 1'b0, k_wb, 1'b0);
    chk("undefined", 16'h1, {15'h0, rsp_out.undefined_overlap});
    variable_range_count_in = 4'h5;
    look(32'h01000000, 1'b0, k_wp, 1'b0);
    variable_range_count_in = 4'h0;
    look(32'h00400000, 1'b0, k_wp, 1'b0);
    req_valid_in = 1'b0;
    step();
    chk("rsp_pulse", 16'h0, {15'h0, rsp_valid_out});
    chk("held_kind", {13'h0, k_wp}, {13'h0, held_kind});
    step();
    chk("responses", issued[15:0], seen_count);
    reset_in = 1'b1;
    step();
    step();
    reset_in = 1'b0;
    chk("ctrl", 16'h0, {11'h0, ctrl_out});
    chk("valid_flags", 16'h0, {8'h0, valid_flags_out});
    look(32'h00400000, 1'b0, k_uc, 1'b0);
    stop_test();
  end
endmodule : mrtl_lookup_tb_top
